// file: verilog/ssx_pkg.sv
package ssx_pkg;

    // =====================================================
    // register map, byte addresses on a 32-bit apb
    localparam logic [7:0] CMD_OFFSET     = 8'h00;
    localparam logic [7:0] ACC_OFFSET     = 8'h04;
    localparam logic [7:0] STATUS_OFFSET  = 8'h08;
    localparam logic [7:0] MEMIDX_OFFSET  = 8'h0C;
    localparam logic [7:0] MEMDATA_OFFSET = 8'h10;

    // =====================================================
    // reset values
    localparam logic [7:0]  ACC_RESET    = 8'h00;
    localparam logic [2:0]  STATUS_RESET = 3'h0;
    localparam logic [6:0]  MEMIDX_RESET = 7'h00;
    localparam logic [7:0]  MEM_RESET    = 8'h00;
    localparam logic [31:0] CMD_RESET    = 32'h0000_0000;

    // =====================================================
    // operation codes
    typedef enum logic [2:0] {
        LIT_MINUS_ACC = 3'b000,
        OPD_MINUS_ACC = 3'b001,
        NIBBLE_XCHG   = 3'b010,
        LIT_XOR_ACC   = 3'b011,
        OPD_XOR_ACC   = 3'b100
    } ssx_op_t;

    // command word: op [2:0], dest [3], addr [14:8], literal [23:16]
    typedef struct packed {
        logic [7:0] rsvdHi;
        logic [7:0] literal;
        logic       rsvdMid;
        logic [6:0] addr;
        logic [3:0] rsvdLo;
        logic       dest;
        ssx_op_t    op;
    } ssx_cmd_t;

    // status word: carry [0], nibble borrow [1], zero [2]
    typedef struct packed {
        logic zero;
        logic nibbleBorrowFlag;
        logic carry;
    } ssx_flags_t;

endpackage

// file: verilog/ssx_alu_ops.sv
// Operation
// - literal minus accumulator into accumulator; update carry, nibble, zero flags
// - memory operand minus accumulator, address 0..127, routed by destination bit
// - destination bit 0 writes accumulator, 1 writes the addressed operand
// - nibble exchange of operand, routed by destination bit, flags untouched
// - accumulator xor literal into accumulator; only zero flag updated
// - accumulator xor memory operand, routed by destination bit; only zero flag
module ssx_alu_ops #(
    parameter int MEM_DEPTH = 128
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               ce,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // core state
    output logic      [7:0]         acc,
    output ssx_pkg::ssx_flags_t     flags
);

    // =====================================================
    // parameter check
    if (MEM_DEPTH < 1 || MEM_DEPTH > 128) begin : g_depth_check
        $error("MEM_DEPTH must lie in 1..128");
    end

    // =====================================================
    // storage
    logic [7:0]        mem [MEM_DEPTH];
    logic [6:0]        memIdx;
    ssx_pkg::ssx_cmd_t lastCmd;

    // =====================================================
    // apb handshake
    // one wait state keeps prdata and pready straight from flip-flops
    logic take;
    logic wrTake;
    logic mapped;
    logic [31:0] next_prdata;
    assign take   = ce && psel && penable && pready;
    assign wrTake = take && pwrite;
    assign mapped = paddr == ssx_pkg::CMD_OFFSET || paddr == ssx_pkg::ACC_OFFSET
                 || paddr == ssx_pkg::STATUS_OFFSET || paddr == ssx_pkg::MEMIDX_OFFSET
                 || paddr == ssx_pkg::MEMDATA_OFFSET;

    function automatic logic [7:0] readMem(input logic [6:0] idx);
        logic [7:0] val;
        val = 8'h00;
        for (int i = 0; i < MEM_DEPTH; i++) begin
            if (idx == 7'(i)) begin
                val = mem[i];
            end
        end
        return val;
    endfunction

    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            ssx_pkg::CMD_OFFSET:     next_prdata = lastCmd;
            ssx_pkg::ACC_OFFSET:     next_prdata = {24'h00_0000, acc};
            ssx_pkg::STATUS_OFFSET:  next_prdata = {29'h0000_0000, flags};
            ssx_pkg::MEMIDX_OFFSET:  next_prdata = {25'h000_0000, memIdx};
            ssx_pkg::MEMDATA_OFFSET: next_prdata = {24'h00_0000, readMem(memIdx)};
            default:                 next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    // =====================================================
    // datapath
    ssx_pkg::ssx_cmd_t cmd;
    logic [7:0] operand;
    logic [7:0] subA;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] result;
    logic       toMem;
    logic       updArith;
    logic       updZero;
    logic       legal;
    logic       exec;

    assign cmd     = ssx_pkg::ssx_cmd_t'(pwdata);
    assign operand = readMem(cmd.addr);
    assign subA    = (cmd.op == ssx_pkg::LIT_MINUS_ACC) ? cmd.literal : operand;
    // subtraction as a plus not-b plus one: carry out means no borrow
    // borrow flag sense
    assign sum9 = {1'b0, subA} + {1'b0, ~acc} + 9'h001;
    assign sum5 = {1'b0, subA[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

    always_comb begin
        result   = 8'h00;
        toMem    = 1'b0;
        updArith = 1'b0;
        updZero  = 1'b0;
        legal    = 1'b1;
        unique case (cmd.op)
            ssx_pkg::LIT_MINUS_ACC: begin
                result   = sum9[7:0];
                updArith = 1'b1;
                updZero  = 1'b1;
            end
            ssx_pkg::OPD_MINUS_ACC: begin
                result   = sum9[7:0];
                toMem    = cmd.dest;
                updArith = 1'b1;
                updZero  = 1'b1;
            end
            ssx_pkg::NIBBLE_XCHG: begin
                result = {operand[3:0], operand[7:4]};
                toMem  = cmd.dest;
            end
            ssx_pkg::LIT_XOR_ACC: begin
                result  = acc ^ cmd.literal;
                updZero = 1'b1;
            end
            ssx_pkg::OPD_XOR_ACC: begin
                result  = acc ^ operand;
                toMem   = cmd.dest;
                updZero = 1'b1;
            end
            // unknown codes execute nothing; lastCmd still takes the command word
            default: legal = 1'b0;
        endcase
    end

    assign exec = wrTake && paddr == ssx_pkg::CMD_OFFSET && legal;

    always_ff @(posedge clk) begin
        if (reset) begin
            lastCmd <= ssx_pkg::ssx_cmd_t'(ssx_pkg::CMD_RESET);
            memIdx  <= ssx_pkg::MEMIDX_RESET;
        end else if (ce && wrTake) begin
            if (paddr == ssx_pkg::CMD_OFFSET) begin
                lastCmd <= cmd;
            end
            if (paddr == ssx_pkg::MEMIDX_OFFSET) begin
                memIdx <= pwdata[6:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            acc <= ssx_pkg::ACC_RESET;
        end else if (ce) begin
            if (exec && !toMem) begin
                acc <= result;
            end else if (wrTake && paddr == ssx_pkg::ACC_OFFSET) begin
                acc <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flags <= ssx_pkg::ssx_flags_t'(ssx_pkg::STATUS_RESET);
        end else if (ce) begin
            if (exec) begin
                if (updArith) begin
                    flags.carry            <= sum9[8];
                    flags.nibbleBorrowFlag <= sum5[4];
                end
                if (updZero) begin
                    flags.zero <= result == 8'h00;
                end
            end else if (wrTake && paddr == ssx_pkg::STATUS_OFFSET) begin
                flags <= ssx_pkg::ssx_flags_t'(pwdata[2:0]);
            end
        end
    end

    for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
        always_ff @(posedge clk) begin
            if (reset) begin
                mem[i] <= ssx_pkg::MEM_RESET;
            end else if (ce) begin
                if (exec && toMem && cmd.addr == 7'(i)) begin
                    mem[i] <= result;
                end else if (wrTake && paddr == ssx_pkg::MEMDATA_OFFSET
                             && memIdx == 7'(i)) begin
                    mem[i] <= pwdata[7:0];
                end
            end
        end
    end

    // =====================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    lit_sub_a: assert property (exec && cmd.op == ssx_pkg::LIT_MINUS_ACC
        |=> acc == 8'($past(cmd.literal) - $past(acc)))
        else $error("literal subtract result wrong");
    opd_sub_a: assert property (exec && cmd.op == ssx_pkg::OPD_MINUS_ACC && !cmd.dest
        |=> acc == 8'($past(operand) - $past(acc)))
        else $error("operand subtract result wrong");
    dest_mem_a: assert property (exec && toMem
        |=> acc == $past(acc) && readMem($past(cmd.addr)) == $past(result))
        else $error("destination one result misrouted");
    swap_flags_a: assert property (exec && cmd.op == ssx_pkg::NIBBLE_XCHG
        |=> flags == $past(flags))
        else $error("nibble exchange touched flags");
    lit_xor_a: assert property (exec && cmd.op == ssx_pkg::LIT_XOR_ACC
        |=> acc == ($past(acc) ^ $past(cmd.literal))
            && flags.carry == $past(flags.carry)
            && flags.nibbleBorrowFlag == $past(flags.nibbleBorrowFlag))
        else $error("literal xor wrong");
    opd_xor_a: assert property (exec && cmd.op == ssx_pkg::OPD_XOR_ACC && !cmd.dest
        |=> acc == ($past(acc) ^ $past(operand)) && flags.carry == $past(flags.carry))
        else $error("operand xor wrong");
    carry_sense_a: assert property (exec && updArith
        |=> flags.carry == ($past(subA) >= $past(acc))
            && flags.nibbleBorrowFlag == ($past(subA[3:0]) >= $past(acc[3:0])))
        else $error("borrow flags wrong");
    zero_flag_a: assert property (exec && updZero
        |=> flags.zero == ($past(result) == 8'h00))
        else $error("zero flag wrong");
    apb_wait_a: assert property (ce && psel && penable && !pready
        |=> pready ##1 (!pready || !$past(ce)))
        else $error("apb wait state wrong");
    // a low enable must hold every output flop, handshake included
    ce_freeze_a: assert property (!ce
        |=> acc == $past(acc) && flags == $past(flags) && pready == $past(pready)
            && prdata == $past(prdata) && pslverr == $past(pslverr))
        else $error("state moved while enable low");

    sub_borrow_c: cover property (exec && updArith && sum9[8] == 1'b0);
    swap_mem_c: cover property (exec && cmd.op == ssx_pkg::NIBBLE_XCHG && cmd.dest);
    xor_zero_c: cover property (exec && cmd.op == ssx_pkg::OPD_XOR_ACC && result == 8'h00);
    ce_stall_c: cover property (!ce && pready);

endmodule

// file: verif/subtract_swap_xor_alu_ops_test.sv
module subtract_swap_xor_alu_ops_test;
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================
    // signals
    logic                clk = 1'b0;
    logic                reset = 1'b1;
    logic                ce = 1'b1;
    logic                stall = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0000_0000;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [7:0]          acc;
    ssx_pkg::ssx_flags_t flags;
    int                  fail_count = 0;
    int                  comparisons = 0;
    int                  seed = 29046;
    logic [31:0]         rdata;
    logic                rerr;
    logic [2:0]          op;
    logic                dest;
    logic [6:0]          ad;
    logic [7:0]          k, w, f, expA, expM;
    logic [2:0]          fl;
    logic [10:0]         e;

    ssx_alu_ops #(.MEM_DEPTH(128)) DUT (
        .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .acc(acc), .flags(flags)
    );

    always #20 clk = ~clk;

    // clock enable drawn at random once stalls are switched on
    always @(posedge clk) begin
        ce <= !stall || (2'($random(seed)) != 2'h0);
    end

    // =====================================================
    // helpers
    task automatic stop_test;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask

    // request held until pready is sampled high with enable high; a spare edge follows
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!(pready === 1'b1 && ce === 1'b1) && n < 50);
        if (n >= 50) fail_count++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // subtraction: carry and nibble flag mean no borrow
    function automatic logic [10:0] sub(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = a - b;
        return {r == 8'h00, a[3:0] >= b[3:0], a >= b, r};
    endfunction

    function automatic logic [10:0] model(input logic [2:0] o, input logic [7:0] wa,
                                          input logic [7:0] fm, input logic [7:0] lit,
                                          input logic [2:0] fo);
        logic [7:0] r;
        case (o)
            3'h0: return sub(lit, wa);
            3'h1: return sub(fm, wa);
            3'h2: return {fo, fm[3:0], fm[7:4]};
            3'h3: begin
                r = wa ^ lit;
                return {r == 8'h00, fo[1:0], r};
            end
            default: begin
                r = wa ^ fm;
                return {r == 8'h00, fo[1:0], r};
            end
        endcase
    endfunction

    // =====================================================
    // watchdog, far beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    // =====================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        xfer(ssx_pkg::STATUS_OFFSET, 1'b0, 32'h0);
        check(rdata, 32'h0);
        check({24'h0, acc}, 32'h0);
        // unmapped address is refused
        xfer(8'h14, 1'b0, 32'h0);
        check({31'h0, rerr}, 32'h1);
        check(rdata, 32'h0);
        // undefined op code leaves the accumulator alone
        xfer(ssx_pkg::ACC_OFFSET, 1'b1, 32'h5A);
        xfer(ssx_pkg::CMD_OFFSET, 1'b1, 32'h0012_0005);
        check({24'h0, acc}, 32'h5A);
        // the refused command word is still stored
        xfer(ssx_pkg::CMD_OFFSET, 1'b0, 32'h0);
        check(rdata, 32'h0012_0005);
        for (int i = 0; i < 150; i++) begin
            stall <= (i >= 75);
            op = 3'($unsigned($random(seed)) % 5);
            dest = 1'($random(seed));
            ad = 7'($random(seed));
            k = 8'($random(seed));
            w = 8'($random(seed));
            f = 8'($random(seed));
            fl = 3'($random(seed));
            if (i < 5) begin
                op = 3'(i);
                ad = (i == 1) ? 7'h7F : 7'h00;
            end
            if (i == 0) k = w;
            if (i == 1) {f, w} = 16'h1001;
            if (i == 3) {k, w} = 16'h00FF;
            if (i == 4) f = w;
            xfer(ssx_pkg::MEMIDX_OFFSET, 1'b1, {25'h0, ad});
            xfer(ssx_pkg::MEMDATA_OFFSET, 1'b1, {24'h0, f});
            xfer(ssx_pkg::ACC_OFFSET, 1'b1, {24'h0, w});
            xfer(ssx_pkg::STATUS_OFFSET, 1'b1, {29'h0, fl});
            xfer(ssx_pkg::CMD_OFFSET, 1'b1, {8'h0, k, 1'b0, ad, 4'h0, dest, op});
            e = model(op, w, f, k, fl);
            expA = e[7:0];
            expM = f;
            if (dest && (op == 3'h1 || op == 3'h2 || op == 3'h4)) begin
                expA = w;
                expM = e[7:0];
            end
            xfer(ssx_pkg::ACC_OFFSET, 1'b0, 32'h0);
            check(rdata, {24'h0, expA});
            check({31'h0, rerr}, 32'h0);
            check({29'h0, flags}, {29'h0, e[10:8]});
            xfer(ssx_pkg::MEMDATA_OFFSET, 1'b0, 32'h0);
            check(rdata, {24'h0, expM});
        end
        stop_test();
    end
endmodule
